// ==== hw/ppe_map.svh ====
/*
 constants of the packet engine: packet sizes, code types, clock rate.
 assumes inclusion by ppe_pkg and the engine; definitions only.
*/
`ifndef PPE_MAP_SVH
`define PPE_MAP_SVH
`define PPE_MAX_BYTES      16
`define PPE_NUM_PKTS       4
`define PPE_CLK_MHZ        100
`define PPE_CODE_BIN       2'h0
`define PPE_CODE_AHEX      2'h1
`define PPE_CODE_ADEC      2'h2
`define PPE_ORDER_FWD      2'h0
`define PPE_ORDER_REV      2'h1
`define PPE_ORDER_SWAP     2'h2
`define PPE_ASCII_ZERO     8'h30
`define PPE_ASCII_ALPHA    8'h37
`define PPE_RES_OK         2'h0
`define PPE_RES_TX_TMO     2'h1
`define PPE_RES_RX_TMO     2'h2
`define PPE_RES_BAD_CFG    2'h3
`endif

// ==== hw/ppe_pkg.sv ====
/*
 types of the packet engine.
 assumes ppe_map.svh is on the include path.
*/
`include "ppe_map.svh"
package ppe_pkg;
   typedef enum logic [2:0] {
      SEND_ONLY = 3'h1,
      RECV_ONLY = 3'h2,
      SEND_RECV = 3'h4
   } ppe_comm_e;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_SEND  = 6'h02,
      ST_DRAIN = 6'h04,
      ST_RECV  = 6'h08,
      ST_DONE  = 6'h10,
      ST_HOLD  = 6'h20
   } ppe_state_e;
   typedef struct packed {
      ppe_comm_e   comm;
      logic [1:0]  lenCode;
      logic [1:0]  lenOrder;
      logic [2:0]  lenUnits;
      logic [3:0]  lenPos;
      logic        lenEnable;
      logic [4:0]  sendCount;
      logic [2:0]  numCand;
      logic [31:0] txTimeout;
      logic [31:0] rxTimeout;
   } ppe_req_s;
   typedef struct packed {
      logic       ok;
      logic [1:0] code;
      logic [2:0] matchIdx;
   } ppe_res_s;
endpackage : ppe_pkg

// ==== hw/ppe_fifo.sv ====
/*
 transmit fifo of the packet engine: declared in ppe_engine.sv beside
 the engine, so that one design file carries all the logic.
 assumes nothing of its surroundings; this file holds no code.
*/

// ==== hw/ppe_engine.sv ====
/*
 predefined protocol packet engine: send, receive matching, length element,
 and the small transmit fifo that the engine feeds.
 assumes the issuing cpu writes packet tables and the uart moves bytes.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ppe_map.svh"

// ----------------------------------------------------------------
// transmit fifo, valid/ready on both sides
// ----------------------------------------------------------------
module ppe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("ppe_fifo depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_reg;
   logic [AW:0]      rdPtr_reg;
   logic             push;
   logic             pop;
   // one spare pointer bit tells full from empty
   assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
   assign outValid = wrPtr_reg != rdPtr_reg;
   assign outData  = mem[rdPtr_reg[AW-1:0]];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         if (push)
            wrPtr_reg <= wrPtr_reg + 1'b1;
         if (pop)
            rdPtr_reg <= rdPtr_reg + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (push)
         mem[wrPtr_reg[AW-1:0]] <= inData;
   end
endmodule : ppe_fifo

module ppe_engine #(
   parameter int MAX_BYTES = `PPE_MAX_BYTES,
   parameter int NUM_PKTS  = `PPE_NUM_PKTS
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   start,
   input  wire ppe_pkg::ppe_req_s      req,
   input  wire logic [31:0]            lenValue,
   input  wire logic [7:0]             txBytes [MAX_BYTES],
   input  wire logic [7:0]             rxBytes [NUM_PKTS][MAX_BYTES],
   input  wire logic [MAX_BYTES-1:0]   rxFixed [NUM_PKTS],
   input  wire logic [4:0]             rxLen   [NUM_PKTS],
   output logic [7:0]                  txData,
   output logic                        txValid,
   input  wire logic                   txReady,
   input  wire logic                   txIdle,
   input  wire logic [7:0]             rxData,
   input  wire logic                   rxValid,
   output logic                        busy,
   output logic                        waitRecv,
   output logic                        done,
   output ppe_pkg::ppe_res_s           result
);
   localparam int PW = $clog2(MAX_BYTES + 1);
   initial begin
      if (MAX_BYTES < 4 || MAX_BYTES > 16 || NUM_PKTS < 1 || NUM_PKTS > 7)
         $error("ppe_engine: MAX_BYTES 4..16, NUM_PKTS 1..7");
   end

   // ----------------------------------------------------------------
   // length element encoding
   // ----------------------------------------------------------------
   function automatic logic [7:0] hexDigit(input logic [3:0] n);
      return (n < 4'ha) ? `PPE_ASCII_ZERO + 8'(n) : `PPE_ASCII_ALPHA + 8'(n);
   endfunction : hexDigit

   // unit k counted from least significant, forward position maps to it
   function automatic logic [7:0] lenUnit(input logic [31:0] v,
                                          input logic [1:0]  code,
                                          input logic [2:0]  k);
      logic [31:0] d;
      d = v;
      for (int i = 0; i < 4; i++)
         if (i < int'(k))
            d = d / 32'd10;
      unique case (code)
         `PPE_CODE_AHEX: return hexDigit(v[k*4 +: 4]);
         `PPE_CODE_ADEC: return `PPE_ASCII_ZERO + 8'(d % 32'd10);
         default:        return v[k*8 +: 8];
      endcase
   endfunction : lenUnit

   function automatic logic [7:0] lenByte(input ppe_pkg::ppe_req_s r,
                                          input logic [31:0] v,
                                          input logic [2:0]  idx);
      logic [2:0] fwd;
      fwd = idx;
      if (r.lenOrder == `PPE_ORDER_REV)
         fwd = r.lenUnits - 3'd1 - idx;
      else if (r.lenOrder == `PPE_ORDER_SWAP)
         fwd = {idx[2:1], ~idx[0]};
      return lenUnit(v, r.lenCode, r.lenUnits - 3'd1 - fwd);
   endfunction : lenByte

   // ----------------------------------------------------------------
   // control state machine
   // ----------------------------------------------------------------
   ppe_pkg::ppe_state_e state_reg;
   ppe_pkg::ppe_req_s   req_reg;
   logic [4:0]          sendIdx_reg;
   logic [31:0]         timer_reg;
   logic [PW-1:0]       pos_reg [NUM_PKTS];
   logic [NUM_PKTS-1:0] hit;
   logic [7:0]          nextTx;
   logic                fifoReady;
   logic                fifoOutValid;
   logic [7:0]          fifoOutData;
   logic                pushTx;
   logic                badCfg;

   // a width/order pair the length element cannot take is refused up front
   assign badCfg = req.lenEnable &&
      (req.lenUnits == 3'd0 || req.lenUnits > 3'd4 ||
       (req.lenOrder == `PPE_ORDER_REV && req.lenUnits == 3'd1) ||
       (req.lenOrder == `PPE_ORDER_SWAP && req.lenUnits != 3'd4) ||
       req.lenOrder == 2'h3);

   always_comb begin
      nextTx = txBytes[sendIdx_reg[3:0]];
      if (req_reg.lenEnable && sendIdx_reg >= 5'(req_reg.lenPos) &&
          sendIdx_reg < 5'(req_reg.lenPos) + 5'(req_reg.lenUnits))
         nextTx = lenByte(req_reg, lenValue,
                          3'(sendIdx_reg - 5'(req_reg.lenPos)));
   end

   assign pushTx = (state_reg == ppe_pkg::ST_SEND) && fifoReady;

   // per-candidate match positions, updated on every arriving byte
   for (genvar p = 0; p < NUM_PKTS; p++) begin : g_cand
      logic [PW-1:0] pos;
      logic          byteOk;
      logic          byteOk0;
      assign pos = pos_reg[p];
      assign byteOk = !rxFixed[p][pos[3:0]] ||
                      rxBytes[p][pos[3:0]] == rxData;
      assign byteOk0 = !rxFixed[p][0] || rxBytes[p][0] == rxData;
      assign hit[p] = (p < int'(req_reg.numCand)) && rxValid &&
                      byteOk && (5'(pos) + 5'd1 == rxLen[p]);
      always_ff @(posedge mclk) begin
         if (!rst_n || state_reg != ppe_pkg::ST_RECV)
            pos_reg[p] <= '0;
         else if (rxValid) begin
            if (byteOk)
               pos_reg[p] <= pos + 1'b1;
            // discard and retry the byte as a fresh first element
            else if (byteOk0)
               pos_reg[p] <= PW'(1);
            else
               pos_reg[p] <= '0;
         end
      end
   end

   function automatic logic [2:0] firstHit(input logic [NUM_PKTS-1:0] h);
      for (int i = 0; i < NUM_PKTS; i++)
         if (h[i])
            return 3'(i + 1);
      return 3'd0;
   endfunction : firstHit

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg   <= ppe_pkg::ST_IDLE;
         req_reg     <= '0;
         sendIdx_reg <= '0;
         timer_reg   <= '0;
         result      <= '0;
         done        <= 1'b0;
         busy        <= 1'b0;
         waitRecv    <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state_reg)
            ppe_pkg::ST_IDLE: begin
               if (start && badCfg) begin
                  result <= '{ok: 1'b0, code: `PPE_RES_BAD_CFG,
                              matchIdx: 3'd0};
                  done   <= 1'b1;
               end else if (start) begin
                  req_reg     <= req;
                  sendIdx_reg <= '0;
                  busy        <= 1'b1;
                  result      <= '0;
                  if (req.comm == ppe_pkg::RECV_ONLY) begin
                     timer_reg <= req.rxTimeout;
                     waitRecv  <= 1'b1;
                     state_reg <= ppe_pkg::ST_RECV;
                  end else begin
                     timer_reg <= req.txTimeout;
                     state_reg <= ppe_pkg::ST_SEND;
                  end
               end
            end
            ppe_pkg::ST_SEND, ppe_pkg::ST_DRAIN: begin
               if (req_reg.txTimeout != 32'd0 && timer_reg == 32'd1) begin
                  result    <= '{ok: 1'b0, code: `PPE_RES_TX_TMO,
                                 matchIdx: 3'd0};
                  state_reg <= ppe_pkg::ST_DONE;
               end else begin
                  if (req_reg.txTimeout != 32'd0)
                     timer_reg <= timer_reg - 32'd1;
                  if (state_reg == ppe_pkg::ST_SEND) begin
                     if (pushTx)
                        sendIdx_reg <= sendIdx_reg + 5'd1;
                     if (pushTx && sendIdx_reg + 5'd1 >= req_reg.sendCount)
                        state_reg <= ppe_pkg::ST_DRAIN;
                  end else if (!fifoOutValid && !txValid && txIdle) begin
                     if (req_reg.comm == ppe_pkg::SEND_RECV) begin
                        timer_reg <= req_reg.rxTimeout;
                        waitRecv  <= 1'b1;
                        state_reg <= ppe_pkg::ST_RECV;
                     end else begin
                        result    <= '{ok: 1'b1, code: `PPE_RES_OK,
                                       matchIdx: 3'd0};
                        state_reg <= ppe_pkg::ST_DONE;
                     end
                  end
               end
            end
            ppe_pkg::ST_RECV: begin
               if (|hit) begin
                  result    <= '{ok: 1'b1, code: `PPE_RES_OK,
                                 matchIdx: firstHit(hit)};
                  state_reg <= ppe_pkg::ST_DONE;
               end else if (timer_reg == 32'd1) begin
                  result    <= '{ok: 1'b0, code: `PPE_RES_RX_TMO,
                                 matchIdx: 3'd0};
                  state_reg <= ppe_pkg::ST_DONE;
               end else if (timer_reg != 32'd0)
                  timer_reg <= timer_reg - 32'd1;
            end
            ppe_pkg::ST_DONE: begin
               done      <= 1'b1;
               busy      <= 1'b0;
               waitRecv  <= 1'b0;
               state_reg <= ppe_pkg::ST_HOLD;
            end
            ppe_pkg::ST_HOLD: begin
               state_reg <= ppe_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // transmit buffer and output stage
   // ----------------------------------------------------------------
   // the output register is a skid of one; the fifo absorbs uart stalls
   ppe_fifo #(
      .WIDTH (8),
      .DEPTH (4)
   ) u_txFifo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inData   (nextTx),
      .inValid  (pushTx),
      .inReady  (fifoReady),
      .outData  (fifoOutData),
      .outValid (fifoOutValid),
      .outReady (!txValid || txReady)
   );

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         txValid <= 1'b0;
         txData  <= 8'h00;
      end else if (!txValid || txReady) begin
         txValid <= fifoOutValid;
         if (fifoOutValid)
            txData <= fifoOutData;
      end
   end
endmodule : ppe_engine
`default_nettype wire

// ==== testbench/ppe_engine_sva.sv ====
/*
 checker for the packet engine's outputs.
 assumes binding to ppe_engine; one clock, sync active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ppe_map.svh"
module ppe_engine_sva (
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire logic              start,
   input wire logic [7:0]        txData,
   input wire logic              txValid,
   input wire logic              txReady,
   input wire logic              rxValid,
   input wire logic              busy,
   input wire logic              waitRecv,
   input wire logic              done,
   input wire ppe_pkg::ppe_res_s result
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_idle_start;
      start && !busy && !done;
   endsequence
   sequence s_launch;
      ##[1:2] (busy || done);
   endsequence
   a_start_runs: assert property (s_idle_start |-> s_launch)
      else $error("start while idle did not launch");
   a_done_pulse: assert property (done |=> !done)
      else $error("done lasted more than one cycle");
   a_done_idle: assert property (done |-> !busy && !waitRecv)
      else $error("busy still up at done");
   a_tx_held: assert property (txValid && !txReady |=>
      txValid && $stable(txData))
      else $error("stalled byte changed");
   a_tx_busy: assert property (txValid |-> busy)
      else $error("byte offered while idle");
   a_recv_quiet: assert property (waitRecv |-> !txValid)
      else $error("sending while waiting for receive");
   a_match_ok: assert property (done && result.matchIdx != 3'h0 |->
      result.ok && result.code == `PPE_RES_OK
      && $past(rxValid, 2))
      else $error("match reported without received byte");
   a_rx_tmo: assert property (done && result.code == `PPE_RES_RX_TMO
      |-> !result.ok && result.matchIdx == 3'h0)
      else $error("receive timeout with match");
   a_tx_tmo: assert property (done && result.code == `PPE_RES_TX_TMO
      |-> !result.ok && result.matchIdx == 3'h0)
      else $error("send timeout flagged ok");
endmodule : ppe_engine_sva
bind ppe_engine ppe_engine_sva ppe_engine_sva_inst (.mclk, .rst_n,
   .start, .txData, .txValid, .txReady, .rxValid, .busy, .waitRecv,
   .done, .result);
`default_nettype wire

// ==== testbench/ppe_uart_model.sv ====
/*
 far-side serial device: sinks sent bytes slowly, sources rx bytes.
 assumes the bench calls send_rx at a falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ppe_uart_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       stallTx,
   input  wire logic [7:0] txData,
   input  wire logic       txValid,
   output logic            txReady,
   output logic            txIdle,
   output logic [7:0]      rxData,
   output logic            rxValid
);
   logic [7:0] got [$];
   logic [2:0] shiftCnt;
   // three cycles of shifting per byte, so the engine must wait
   assign txReady = !stallTx && shiftCnt == 3'h0;
   assign txIdle  = shiftCnt == 3'h0;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shiftCnt <= 3'h0;
      end else if (txValid && txReady) begin
         shiftCnt <= 3'h3;
         got.push_back(txData);
      end else if (shiftCnt != 3'h0) begin
         shiftCnt <= shiftCnt - 3'h1;
      end
   end
   initial begin
      rxValid = 1'b0;
      rxData  = 8'h00;
   end
   // line shows the inverse after the strobe, never a stale copy
   task automatic send_rx(input logic [7:0] b);
      @(negedge mclk);
      rxData  = b;
      rxValid = 1'b1;
      @(negedge mclk);
      rxValid = 1'b0;
      rxData  = ~b;
   endtask : send_rx
endmodule : ppe_uart_model
`default_nettype wire

// ==== testbench/ppe_engine_test.sv ====
/*
 self-checking bench: length coding, matching, timeouts, fifo.
 assumes ppe_uart_model and the checker bind are compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module ppe_engine_test;
   logic              mclk, rst_n, start, stallTx, txReady, txIdle;
   logic              rxValid, txValid, busy, waitRecv, done;
   ppe_pkg::ppe_req_s req;
   ppe_pkg::ppe_res_s result;
   logic [31:0]       lenValue;
   logic [7:0]        txBytes [16];
   logic [7:0]        rxBytes [4][16];
   logic [15:0]       rxFixed [4];
   logic [4:0]        rxLen   [4];
   logic [7:0]        txData, rxData;
   int                failures = 0, checks_done = 0, cyc = 0;
   ppe_engine ppe_engine_inst (.mclk, .rst_n, .start, .req, .lenValue,
      .txBytes, .rxBytes, .rxFixed, .rxLen, .txData, .txValid, .txReady,
      .txIdle, .rxData, .rxValid, .busy, .waitRecv, .done, .result);
   ppe_uart_model uart_inst (.mclk, .rst_n, .stallTx, .txData,
      .txValid, .txReady, .txIdle, .rxData, .rxValid);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   // ------------------------------------------------------------
   // shared steps
   // ------------------------------------------------------------
   task automatic wait_hi(ref logic s);
      int k;
      k = 0;
      while (s !== 1'b1 && k < 3000) begin
         @(negedge mclk);
         k++;
      end
      check(32'(s), 32'h1);
   endtask : wait_hi
   // two idle cycles keep the restart spacing after done
   task automatic go;
      repeat (2) @(negedge mclk);
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
   endtask : go
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // a stalled sink fills the transmit buffer; order must survive it
   task automatic fifo_case;
      req.lenEnable = 1'b0;
      req.sendCount = 5'h8;
      foreach (txBytes[i]) txBytes[i] = 8'h40 + 8'(i);
      uart_inst.got.delete();
      stallTx = 1'b1;
      go();
      repeat (12) @(negedge mclk);
      check(32'(busy), 32'h1);
      check(32'(txValid), 32'h1);
      check(32'(txData), 32'h40);
      check(32'(uart_inst.got.size()), 32'h0);
      stallTx = 1'b0;
      wait_hi(done);
      check(32'(result.code), 32'h0);
      check(32'(uart_inst.got.size()), 32'h8);
      for (int k = 0; k < 8; k++)
         check(32'(uart_inst.got[k]), 32'h40 + 32'(k));
      foreach (txBytes[i]) txBytes[i] = i == 0 ? 8'ha5 : 8'h5a;
      req.lenEnable = 1'b1;
   endtask : fifo_case
   task automatic len_case(input logic [1:0] c, input logic [1:0] o,
                           input logic [2:0] n);
      logic [7:0] u [4];
      logic [3:0] nb;
      logic       bad;
      int         d, j;
      bad = (o == 2'h1 && n == 3'h1) || (o == 2'h2 && n != 3'h4);
      d = 1;
      for (int k = 0; k < 4; k++) begin
         nb = lenValue[4*k +: 4];
         u[k] = c == 2'h0 ? lenValue[8*k +: 8]
              : c == 2'h1 ? {4'h0, nb} + (nb < 4'ha ? 8'h30 : 8'h37)
              : 8'h30 + 8'((lenValue / d) % 10);
         d = d * 10;
      end
      req.comm = ppe_pkg::SEND_ONLY;
      req.lenCode = c;
      req.lenOrder = o;
      req.lenUnits = n;
      req.sendCount = 5'(n) + 5'h2;
      uart_inst.got.delete();
      go();
      wait_hi(done);
      check(32'(result.code), bad ? 32'h3 : 32'h0);
      if (!bad) begin
         check(32'(uart_inst.got.size()), 32'(n) + 32'h2);
         check(32'(uart_inst.got[0]), 32'ha5);
         for (int i = 0; i < n; i++) begin
            j = o == 2'h0 ? n - 1 - i : o == 2'h1 ? i : n - 1 - (i ^ 1);
            check(32'(uart_inst.got[i+1]), 32'(u[j]));
         end
      end
   endtask : len_case
   task automatic rx_case(input ppe_pkg::ppe_comm_e m,
                          input logic [7:0] b [$],
                          input logic [2:0] idx, input logic [1:0] code);
      req.comm = m;
      uart_inst.got.delete();
      go();
      wait_hi(waitRecv);
      check(32'(uart_inst.got.size()),
            m == ppe_pkg::SEND_RECV ? 32'(req.sendCount) : 32'h0);
      foreach (b[i]) uart_inst.send_rx(b[i]);
      wait_hi(done);
      check(32'(result.matchIdx), 32'(idx));
      check(32'(result.code), 32'(code));
   endtask : rx_case
   task automatic tx_tmo_case;
      req.comm = ppe_pkg::SEND_ONLY;
      req.txTimeout = 32'd20;
      stallTx = 1'b1;
      go();
      wait_hi(done);
      check(32'(result.code), 32'h1);
      check(32'(result.ok), 32'h0);
      stallTx = 1'b0;
   endtask : tx_tmo_case
   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      stallTx = 1'b0;
      lenValue = 32'd258;
      req = '0;
      req.comm = ppe_pkg::SEND_ONLY;
      req.lenPos = 4'h1;
      req.lenEnable = 1'b1;
      req.numCand = 3'h3;
      foreach (txBytes[i]) txBytes[i] = i == 0 ? 8'ha5 : 8'h5a;
      foreach (rxBytes[p, i]) rxBytes[p][i] = 8'h00;
      rxBytes[0][0] = 8'h11;
      rxBytes[0][2] = 8'h33;
      rxBytes[1][0] = 8'h11;
      rxBytes[1][1] = 8'h22;
      rxBytes[1][2] = 8'h33;
      rxBytes[2][0] = 8'h55;
      rxBytes[2][1] = 8'h66;
      // middle byte of the first candidate is a variable element
      rxFixed = '{16'h0005, 16'hffff, 16'hffff, 16'hffff};
      rxLen = '{5'h3, 5'h3, 5'h2, 5'h1};
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      fifo_case();
      for (int c = 0; c < 3; c++)
         for (int o = 0; o < 3; o++)
            for (int n = 1; n < 5; n++)
               len_case(2'(c), 2'(o), 3'(n));
      rx_case(ppe_pkg::RECV_ONLY, {8'h11, 8'h22, 8'h33}, 3'h1, 2'h0);
      rx_case(ppe_pkg::RECV_ONLY, {8'h11, 8'h77, 8'h33}, 3'h1, 2'h0);
      rx_case(ppe_pkg::RECV_ONLY, {8'h55, 8'h55, 8'h66}, 3'h3, 2'h0);
      rx_case(ppe_pkg::SEND_RECV, {8'h55, 8'h66}, 3'h3, 2'h0);
      req.rxTimeout = 32'd50;
      rx_case(ppe_pkg::RECV_ONLY, {8'h99}, 3'h0, 2'h2);
      tx_tmo_case();
      tally_and_finish();
   end
endmodule : ppe_engine_test
`default_nettype wire
